// ==== design/asc_pkg.sv ====
package asc_pkg;
    localparam int NUM_CH = 14;
    localparam logic [15:0] CH_SETTLE_BASE = 16'ha410;
    localparam logic [15:0] GLOBAL_SETTLE_ADDR = 16'hab80;
    localparam logic [15:0] STREAM_SETTLE_ADDR = 16'h0fa8;
    localparam logic [15:0] CH_STEP = 16'h0002;
    localparam logic [31:0] STREAM_SETTLE_RESET = 32'h00000000;
    localparam logic [31:0] CH_SETTLE_RESET = 32'h00000000;
    localparam logic [31:0] MIXED_VALUE = 32'hc61c3c00;
    localparam logic [31:0] SETTLE_MAX_US = 32'h0000c350;
    localparam logic [31:0] SETTLE_MAX_FLOAT = 32'h47435000;
    localparam logic [31:0] FLOAT_ONE = 32'h3f800000;
    localparam int CLK_MHZ = 100;
    localparam int US_CYCLES = CLK_MHZ;
    localparam logic [31:0] AUTO_SETTLE_US = 32'h00000032;
    localparam logic [31:0] AUTO_STREAM_US = 32'h0000000a;

    typedef struct packed {
        logic valid;
        logic write;
        logic [15:0] addr;
        logic [31:0] wdata;
    } asc_req_t;

    typedef struct packed {
        logic valid;
        logic refused;
        logic [31:0] rdata;
    } asc_rsp_t;

    typedef struct packed {
        logic start;
        logic stream;
        logic first;
        logic [3:0] channel;
    } asc_conv_t;
endpackage : asc_pkg

// ==== design/asc_settle_ctrl.sv ====
// Operation
// R1: Wait settling from mux switch before sampling
// R2: Zero settling value selects automatic settling
// R3: Float per-channel registers from 42000 govern reads
// R4: Channel settling ignored during streaming
// R5: Global write sets all; mixed reads -9999
// R6: Host keeps settling at most 50000 us
// R7: Stream settling defaults zero; below one auto
// R8: Stream settling skips first scan entry
// R9: Streams use stream resolution setting
// R10: Refuse analog reads while streaming
// R11: Float registers step two addresses apart
// R12: Channel N at base plus 2N
// R13: Command reads calibrated; binary path raw
// R14: Streamed data delivered raw uncalibrated
// R15: Clamp written settling above maximum

`timescale 1ns/1ps
module asc_settle_ctrl (
    input wire logic mclk,
    input wire logic rst_n,
    input wire asc_pkg::asc_req_t req,
    output asc_pkg::asc_rsp_t rsp,
    input wire logic stream_active,
    input wire asc_pkg::asc_conv_t conv,
    input wire logic [3:0] cr_resolution,
    input wire logic [3:0] stream_resolution,
    input wire logic cr_read_calibrated,
    output logic [3:0] active_resolution,
    output logic calibrate_en,
    output logic sample_strobe,
    output logic [3:0] sample_channel,
    output logic busy
);
    typedef enum logic [1:0] {
        ASC_IDLE = 2'b01,
        ASC_WAIT = 2'b10
    } asc_state_t;

    logic [31:0] ch_settle [asc_pkg::NUM_CH];
    logic [31:0] stream_settle;
    asc_state_t state;
    logic [31:0] us_left;
    logic [7:0] cyc_cnt;
    logic [3:0] cur_ch;

    // Address decode
    wire logic [15:0] ch_off = req.addr - asc_pkg::CH_SETTLE_BASE;
    // Channel window: even offsets only, one float per two addresses
    wire logic ch_above = req.addr >= asc_pkg::CH_SETTLE_BASE;
    wire logic ch_even = !ch_off[0];
    wire logic ch_in_map = ch_off[15:1] < 15'(asc_pkg::NUM_CH);
    wire logic ch_hit = ch_above && ch_even && ch_in_map; // [R3] [R11]
    wire logic [3:0] ch_idx = ch_off[4:1]; // [R12]
    wire logic glb_hit = req.addr == asc_pkg::GLOBAL_SETTLE_ADDR;
    wire logic str_hit = req.addr == asc_pkg::STREAM_SETTLE_ADDR;
    wire logic wr = req.valid && req.write;
    wire logic rd = req.valid && !req.write;

    // Float compare above max; positive floats order as integers
    wire logic wdata_pos = !req.wdata[31];
    wire logic over_max = wdata_pos && (req.wdata[30:0] > asc_pkg::SETTLE_MAX_FLOAT[30:0]);
    wire logic [31:0] wval = over_max ? asc_pkg::SETTLE_MAX_FLOAT : req.wdata; // [R15]

    // Global read is only meaningful when every channel agrees
    wire logic [asc_pkg::NUM_CH-1:0] ch_same;
    genvar h;
    generate
        for (h = 0; h < asc_pkg::NUM_CH; h++) begin : g_same
            assign ch_same[h] = ch_settle[h] == ch_settle[0];
        end
    endgenerate
    wire logic all_same = &ch_same;

    wire logic [31:0] glb_read = all_same ? ch_settle[0] : asc_pkg::MIXED_VALUE; // [R5]

    // Read mux; unmapped addresses read as zero
    wire logic [31:0] next_rdata =
        ch_hit ? ch_settle[ch_idx] :
        glb_hit ? glb_read :
        str_hit ? stream_settle :
        32'h00000000;
    // Writes answer with zero data
    wire logic [31:0] next_rsp_data = rd ? next_rdata : 32'h00000000;

    // Per-channel settling registers; the global address writes them all
    wire logic [asc_pkg::NUM_CH-1:0] ch_we;
    genvar g;
    generate
        for (g = 0; g < asc_pkg::NUM_CH; g++) begin : g_ch
            assign ch_we[g] = wr && (glb_hit || (ch_hit && ch_idx == 4'(g))); // [R5]
            always_ff @(posedge mclk) begin
                if (!rst_n) begin
                    ch_settle[g] <= asc_pkg::CH_SETTLE_RESET;
                end else if (ch_we[g]) begin
                    ch_settle[g] <= wval; // [R5]
                end
            end
        end
    endgenerate
    // Stream settling register

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            stream_settle <= asc_pkg::STREAM_SETTLE_RESET; // [R7]
        end else if (wr && str_hit) begin
            stream_settle <= wval;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rsp <= '0;
        end else begin
            rsp.valid <= req.valid;
            rsp.refused <= 1'b0;
            rsp.rdata <= next_rsp_data;
        end
    end

    // Float to whole microseconds (truncating), limited to max
    function automatic logic [31:0] asc_f2us(input logic [31:0] f);
        logic [7:0] e;
        logic [31:0] m;
        logic [7:0] sh;
        e = f[30:23];
        m = {8'h00, 1'b1, f[22:0]};
        sh = 8'd150 - e;
        // Negatives and values below one microsecond convert to zero microseconds
        if (f[31] || e < 8'd127) begin
            asc_f2us = 32'h00000000;
        end else if (e > 8'd142) begin
            asc_f2us = asc_pkg::SETTLE_MAX_US;
        end else begin
            asc_f2us = m >> sh;
        end
    endfunction : asc_f2us

    // Channel codes past the last input use channel 0 settling; sample_channel still reports the code as given
    wire logic conv_ch_ok = conv.channel < 4'(asc_pkg::NUM_CH);
    wire logic [3:0] conv_ch = conv_ch_ok ? conv.channel : 4'h0;

    // Settling sources for the next conversion
    wire logic [31:0] sel_ch_f = ch_settle[conv_ch];
    wire logic [31:0] ch_us = asc_f2us(sel_ch_f);
    wire logic [31:0] str_us = asc_f2us(stream_settle);
    wire logic str_neg = stream_settle[31];
    wire logic str_below_one = stream_settle[30:0] < asc_pkg::FLOAT_ONE[30:0];
    wire logic str_auto = str_neg || str_below_one; // [R7]
    // Zero selects the automatic interval
    wire logic [31:0] ch_wait = (sel_ch_f[30:0] == 31'h0) ? asc_pkg::AUTO_SETTLE_US : ch_us; // [R2]
    wire logic [31:0] str_wait = str_auto ? asc_pkg::AUTO_STREAM_US : str_us;
    // First scan entry settles in the scan gap, so it samples at once
    wire logic [31:0] next_wait = conv.stream
        ? (conv.first ? 32'h0 : str_wait)
        : ch_wait; // [R4] [R8]
    // Command conversions refused while streaming
    wire logic conv_ok = conv.start && (conv.stream || !stream_active); // [R10]

    // Timer: whole microseconds of US_CYCLES clocks each
    wire logic wait_done = us_left == 32'h0;
    wire logic us_tick = cyc_cnt == 8'(asc_pkg::US_CYCLES - 1);

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state <= ASC_IDLE;
            us_left <= 32'h0;
            cyc_cnt <= 8'h0;
            cur_ch <= 4'h0;
            sample_strobe <= 1'b0;
            sample_channel <= 4'h0;
            busy <= 1'b0;
        end else begin
            sample_strobe <= 1'b0;
            case (state)
                ASC_IDLE: begin
                    if (conv_ok) begin
                        state <= ASC_WAIT;
                        us_left <= next_wait;
                        cyc_cnt <= 8'h0;
                        cur_ch <= conv.channel;
                        busy <= 1'b1;
                    end
                end
                ASC_WAIT: begin
                    if (wait_done) begin
                        sample_strobe <= 1'b1; // [R1]
                        sample_channel <= cur_ch;
                        busy <= 1'b0;
                        state <= ASC_IDLE;
                    end else if (us_tick) begin
                        cyc_cnt <= 8'h0;
                        us_left <= us_left - 32'h1; // [R1]
                    end else begin
                        cyc_cnt <= cyc_cnt + 8'h1;
                    end
                end
                default: state <= ASC_IDLE;
            endcase
        end
    end

    // Resolution and calibration path follow the stream state
    wire logic [3:0] next_resolution = stream_active ? stream_resolution : cr_resolution; // [R9]
    wire logic next_calibrate = !stream_active && cr_read_calibrated; // [R13] [R14]

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            active_resolution <= 4'h0;
        end else begin
            active_resolution <= next_resolution; // [R9]
        end
    end

    // Streamed codes leave uncalibrated
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            calibrate_en <= 1'b0;
        end else begin
            calibrate_en <= next_calibrate; // [R13] [R14]
        end
    end
endmodule : asc_settle_ctrl

// ==== tb/asc_settle_ctrl_assertions.sv ====
`timescale 1ns/1ps
module asc_settle_ctrl_chk (
    input wire logic mclk,
    input wire logic rst_n,
    input wire asc_pkg::asc_req_t req,
    input wire asc_pkg::asc_rsp_t rsp,
    input wire logic stream_active,
    input wire asc_pkg::asc_conv_t conv,
    input wire logic [3:0] cr_resolution,
    input wire logic [3:0] stream_resolution,
    input wire logic cr_read_calibrated,
    input wire logic [3:0] active_resolution,
    input wire logic calibrate_en,
    input wire logic sample_strobe,
    input wire logic [3:0] sample_channel,
    input wire logic busy
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    reg_answer_a:
        assert property (req.valid |=> rsp.valid && !rsp.refused) else $error("no answer");
    stream_raw_a:
        assert property (stream_active |=> !calibrate_en) else $error("stream calibrated");
    cr_cal_a:
        assert property (!stream_active && cr_read_calibrated |=> calibrate_en) else $error("not calibrated");
    stream_res_a:
        assert property (stream_active |=> active_resolution == $past(stream_resolution)) else $error("res");
    cr_res_a:
        assert property (!stream_active |=> active_resolution == $past(cr_resolution)) else $error("res");
    cr_refuse_a:
        assert property (conv.start && !conv.stream && stream_active && !busy |=> !busy) else $error("taken");
    first_entry_a:
        assert property (conv.start && conv.stream && conv.first && !busy |=> busy ##1 sample_strobe)
        else $error("first");
    stream_wait_a:
        assert property (conv.start && conv.stream && !conv.first && !busy |=> busy [*8]) else $error("short");
    strobe_end_a:
        assert property (sample_strobe |-> $past(busy) && !busy) else $error("strobe");
    cover property (conv.start && conv.stream && conv.first);
    cover property (conv.start && !conv.stream && stream_active);
    cover property (sample_strobe && !stream_active);
endmodule : asc_settle_ctrl_chk
bind asc_settle_ctrl asc_settle_ctrl_chk chk_i (.*);

// ==== tb/asc_host_model.sv ====
`timescale 1ns/1ps
module asc_host_model (
    input wire logic mclk,
    input wire asc_pkg::asc_rsp_t rsp,
    output asc_pkg::asc_req_t req
);
    initial req = '0;
    // Values stay within the host limit unless a scenario asks otherwise
    task acc(input logic w, input logic [15:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge mclk);
        req <= '{1'b1, w, a, d};
        @(posedge mclk);
        req <= '0;
        #1 q = rsp.rdata;
    endtask : acc
endmodule : asc_host_model

// ==== tb/test_asc_settle_ctrl.sv ====
`timescale 1ns/1ps
module test_asc_settle_ctrl;
    logic mclk = 1'b0, rst_n = 1'b0, stream_active = 1'b0, cr_read_calibrated = 1'b1;
    logic [3:0] cr_resolution = 4'h3, stream_resolution = 4'h5, active_resolution, sample_channel;
    logic calibrate_en, sample_strobe, busy;
    logic [31:0] q;
    asc_pkg::asc_req_t req;
    asc_pkg::asc_rsp_t rsp;
    asc_pkg::asc_conv_t conv = '0;
    int num_errors = 0, n_tests = 0;
    asc_settle_ctrl DUT (.*);
    asc_host_model HOST (.mclk(mclk), .rsp(rsp), .req(req));
    task chk(input string s, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            num_errors++;
            $display("unexpected %s expected %h seen %h", s, e, g);
        end
    endtask : chk
    task wr(input logic [15:0] a, input logic [31:0] d);
        HOST.acc(1'b1, a, d, q);
    endtask : wr
    task rd(input logic [15:0] a, input logic [31:0] e, input string s);
        HOST.acc(1'b0, a, 32'h0, q);
        chk(s, e, q);
    endtask : rd
    task cv(input logic s, input logic f, input logic [3:0] c, input logic [31:0] e);
        logic [31:0] n;
        n = 0;
        @(posedge mclk);
        conv <= '{1'b1, s, f, c};
        @(posedge mclk);
        conv <= '0;
        do begin
            @(posedge mclk);
            #1 n++;
        end while (sample_strobe !== 1'b1 && n < 6000);
        chk("settle cycles", e, n);
        chk("channel", {28'h0, c}, {28'h0, sample_channel});
    endtask : cv
    task t_regs;
        rd(16'h0fa8, 32'h0, "stream reset");
        wr(16'hab80, 32'h43fa0000);
        rd(16'ha416, 32'h43fa0000, "ch3");
        rd(16'hab80, 32'h43fa0000, "global");
        wr(16'ha416, 32'h40000000);
        rd(16'hab80, asc_pkg::MIXED_VALUE, "mixed");
        rd(16'ha418, 32'h43fa0000, "ch4");
        rd(16'ha417, 32'h0, "odd");
        wr(16'ha41a, 32'h476a6000);
        rd(16'ha41a, asc_pkg::SETTLE_MAX_FLOAT, "clamp");
    endtask : t_regs
    task t_cmd;
        cv(1'b0, 1'b0, 4'h3, 201);
        wr(16'ha41a, 32'h0);
        cv(1'b0, 1'b0, 4'h5, 5001);
        chk("calibrate cmd", 32'h1, {31'h0, calibrate_en});
    endtask : t_cmd
    task t_stream;
        @(posedge mclk);
        stream_active <= 1'b1;
        @(posedge mclk);
        conv <= '{1'b1, 1'b0, 1'b0, 4'h3};
        @(posedge mclk);
        conv <= '0;
        #1 chk("refused", 32'h0, {31'h0, busy});
        chk("resolution", 32'h5, {28'h0, active_resolution});
        cv(1'b1, 1'b1, 4'h3, 1);
        cv(1'b1, 1'b0, 4'h4, 1001);
        wr(16'h0fa8, 32'h40400000);
        cv(1'b1, 1'b0, 4'h2, 301);
        chk("calibrate", 32'h0, {31'h0, calibrate_en});
    endtask : t_stream
    task complete_run;
        if (num_errors == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : complete_run
    initial begin
        forever #5 mclk = ~mclk;
    end
    initial begin
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        t_regs();
        t_cmd();
        t_stream();
        complete_run();
    end
    initial begin
        #200000;
        num_errors++;
        complete_run();
    end
endmodule : test_asc_settle_ctrl
